// file: logic/tsp_pkg.sv
`default_nettype none
package tsp_pkg;
  localparam int MAX_DATA_W    = 256;
  localparam int MAX_BYTES     = MAX_DATA_W / 8;
  localparam int MAX_DWORDS    = MAX_DATA_W / 32;
  localparam int REQ_SB_W      = 88;
  localparam int CPL_SB_W      = 33;
  localparam int SB_LEAD_LSB   = 0;
  localparam int SB_TRAIL_LSB  = 4;
  localparam int SB_BYTEEN_LSB = 8;
  localparam int SB_SOP_BIT    = 40;
  localparam int SB_ABORT_BIT  = 41;
  localparam int SB_HINT_BIT   = 42;
  localparam int SB_HTYPE_LSB  = 43;
  localparam int SB_TAG_LSB    = 45;
  localparam int SB_PAR_LSB    = 53;
  localparam int CSB_ABORT_BIT = 0;
  localparam int CSB_PAR_LSB   = 1;
  localparam logic [3:0] MASK_ALL_ONES = 4'hF;

  function automatic logic [MAX_BYTES-1:0] tsp_odd_parity(input logic [MAX_DATA_W-1:0] d);
    logic [MAX_BYTES-1:0] p;
    p = '0;
    for (int i = 0; i < MAX_BYTES; i++)
    begin
      p[i] = ~^d[8*i +: 8];
    end
    return p;
  endfunction

  function automatic logic [MAX_BYTES-1:0] tsp_lane_mask(input int data_w);
    logic [MAX_BYTES-1:0] m;
    m = '0;
    for (int i = 0; i < MAX_BYTES; i++)
    begin
      m[i] = (i < data_w / 8);
    end
    return m;
  endfunction
endpackage
`default_nettype wire

// file: logic/tsp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tsp_link_if
  import tsp_pkg::*;
(
  input wire logic clk,     // Shared user clock.
  input wire logic sys_rst  // Asynchronous reset, active high.
);
  logic [MAX_DATA_W-1:0] req_out_data;
  logic [REQ_SB_W-1:0]   req_out_sideband;
  logic                  req_out_valid;
  logic                  req_out_ready;
  logic                  req_out_last;
  logic [MAX_DATA_W-1:0] cpl_in_data;
  logic [CPL_SB_W-1:0]   cpl_in_sideband;
  logic                  cpl_in_valid;
  logic                  cpl_in_ready;
  logic                  cpl_in_last;
  logic [MAX_DWORDS-1:0] cpl_in_dword_keep;

  modport device_end (
    input  clk, sys_rst, req_out_ready, cpl_in_data, cpl_in_sideband, cpl_in_valid,
           cpl_in_last, cpl_in_dword_keep,
    output req_out_data, req_out_sideband, req_out_valid, req_out_last, cpl_in_ready
  );
  modport user_end (
    input  clk, sys_rst, req_out_data, req_out_sideband, req_out_valid, req_out_last,
           cpl_in_ready,
    output req_out_ready, cpl_in_data, cpl_in_sideband, cpl_in_valid, cpl_in_last,
           cpl_in_dword_keep
  );
endinterface
`default_nettype wire

// file: logic/tsp_device_end.sv
`timescale 1ns/1ps
`default_nettype none
module tsp_device_end
#(
  parameter int DATA_W = 256
)
(
  tsp_link_if.device_end                 lnk,               // Link to the user end.
  input  wire logic                      rx_valid,          // Received beat offered.
  output logic                           rx_ready,          // Buffer can take a beat.
  input  wire logic [tsp_pkg::MAX_DATA_W-1:0] rx_data,      // Received beat data.
  input  wire logic                      rx_last,           // Last beat of packet.
  input  wire logic [3:0]                rx_lead_mask,      // Header first-Dword enables.
  input  wire logic [3:0]                rx_trail_mask,     // Header last-Dword enables.
  input  wire logic                      rx_atomic_or_msg,  // Atomic or message with data.
  input  wire logic                      rx_has_payload,    // Packet carries payload.
  input  wire logic                      rx_zero_len,       // Zero-length memory write.
  input  wire logic [tsp_pkg::MAX_BYTES-1:0] rx_payload_bytes, // Bytes that are payload.
  input  wire logic                      rx_fifo_err,       // Payload read error this beat.
  input  wire logic                      rx_hint_present,   // Processing hint present.
  input  wire logic [1:0]                rx_hint_kind,      // Hint PH value.
  input  wire logic [7:0]                rx_hint_steering_tag, // Hint steering tag.
  input  wire logic                      endpoint_mode,     // Device is an endpoint.
  output logic                           aer_report,        // Pulse: report error via AER.
  output logic                           internal_err,      // Pulse: uncorrectable error.
  output logic                           tx_valid,          // Completion beat to link.
  input  wire logic                      tx_ready,          // Link takes the beat.
  output logic [tsp_pkg::MAX_DATA_W-1:0] tx_data,           // Completion beat data.
  output logic [tsp_pkg::MAX_DWORDS-1:0] tx_keep,           // Valid Dwords of beat.
  output logic                           tx_last,           // Last completion beat.
  output logic                           tx_nullify         // Packet is to be nullified.
);
  import tsp_pkg::*;

  if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256)
  begin : g_bad_width
    $error("DATA_W must be 64, 128 or 256.");
  end

  localparam int ENTRY_W = MAX_DATA_W + REQ_SB_W + 1;
  localparam logic [MAX_BYTES-1:0]  LANES = tsp_lane_mask(DATA_W);
  localparam logic [MAX_DWORDS-1:0] KEEP_LANES = MAX_DWORDS'(LANES >> 0) &
                                                 MAX_DWORDS'((1 << (DATA_W / 32)) - 1);
  localparam logic [MAX_DATA_W-1:0] DATA_LANES = MAX_DATA_W'({MAX_DATA_W{1'b1}} >>
                                                 (MAX_DATA_W - DATA_W));

  // Request path: sideband assembly in front of a two-entry buffer.
  logic                  in_pkt_reg;
  logic                  err_pend_reg;
  logic                  rx_take;
  logic                  first_beat;
  logic                  abort_now;
  logic [MAX_DATA_W-1:0] data_in;
  logic [REQ_SB_W-1:0]   sb_in;

  assign rx_take    = rx_valid && rx_ready;
  assign first_beat = !in_pkt_reg;
  assign data_in    = rx_data & DATA_LANES;
  assign abort_now  = rx_last && rx_has_payload && (err_pend_reg || rx_fifo_err);

  always_comb
  begin
    sb_in = '0;
    if (first_beat)
    begin
      sb_in[SB_LEAD_LSB +: 4]  = rx_atomic_or_msg ? MASK_ALL_ONES : rx_lead_mask;
      sb_in[SB_TRAIL_LSB +: 4] = rx_atomic_or_msg ? MASK_ALL_ONES : rx_trail_mask;
      sb_in[SB_HINT_BIT]       = rx_hint_present;
      sb_in[SB_HTYPE_LSB +: 2] = rx_hint_kind;
      sb_in[SB_TAG_LSB +: 8]   = rx_hint_steering_tag;
    end
    // Contiguity of the payload bytes comes from the source's byte marking.
    sb_in[SB_BYTEEN_LSB +: MAX_BYTES] = (rx_zero_len || !rx_has_payload) ? '0 :
                                        (rx_payload_bytes & LANES);
    sb_in[SB_SOP_BIT]   = first_beat;
    sb_in[SB_ABORT_BIT] = abort_now;
    sb_in[SB_PAR_LSB +: MAX_BYTES] = tsp_odd_parity(data_in) & LANES;
  end

  always_ff @(posedge lnk.clk or posedge lnk.sys_rst)
  begin
    if (lnk.sys_rst)
    begin
      in_pkt_reg   <= 1'b0;
      err_pend_reg <= 1'b0;
    end
    else if (rx_take)
    begin
      in_pkt_reg   <= !rx_last;
      err_pend_reg <= !rx_last && rx_has_payload && (err_pend_reg || rx_fifo_err);
    end
  end

  // Two entries let the buffer accept every cycle while the user keeps up,
  // and a user stall only pushes back on the source once both are full.
  logic [ENTRY_W-1:0] buf_mem [2];
  logic               wr_ptr_reg;
  logic               rd_ptr_reg;
  logic [1:0]         count_reg;
  logic               out_take;

  assign rx_ready = (count_reg != 2'h2);
  assign out_take = lnk.req_out_valid && lnk.req_out_ready;

  always_ff @(posedge lnk.clk or posedge lnk.sys_rst)
  begin
    if (lnk.sys_rst)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (rx_take)
      begin
        wr_ptr_reg <= !wr_ptr_reg;
      end
      if (out_take)
      begin
        rd_ptr_reg <= !rd_ptr_reg;
      end
      count_reg <= count_reg + 2'(rx_take) - 2'(out_take);
    end
  end

  always_ff @(posedge lnk.clk or posedge lnk.sys_rst)
  begin
    if (lnk.sys_rst)
    begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
    end
    else if (rx_take)
    begin
      buf_mem[wr_ptr_reg] <= {rx_last, sb_in, data_in};
    end
  end

  // The head entry stays put until the user takes it.
  assign lnk.req_out_valid    = (count_reg != 2'h0);
  assign lnk.req_out_data     = buf_mem[rd_ptr_reg][MAX_DATA_W-1:0];
  assign lnk.req_out_sideband = buf_mem[rd_ptr_reg][MAX_DATA_W +: REQ_SB_W];
  assign lnk.req_out_last     = buf_mem[rd_ptr_reg][ENTRY_W-1];

  // Completion path: one output stage toward the link.
  logic                  tx_valid_reg;
  logic [MAX_DATA_W-1:0] tx_data_reg;
  logic [MAX_DWORDS-1:0] tx_keep_reg;
  logic                  tx_last_reg;
  logic                  tx_nullify_reg;
  logic                  bad_pkt_reg;
  logic                  cpl_take;
  logic                  cpl_abort;
  logic                  cpl_par_err;
  logic [MAX_BYTES-1:0]  cpl_par;

  assign lnk.cpl_in_ready = !tx_valid_reg || tx_ready;
  assign cpl_take  = lnk.cpl_in_valid && lnk.cpl_in_ready;
  // Abort is only looked at while ready is high.
  assign cpl_abort = lnk.cpl_in_sideband[CSB_ABORT_BIT];
  assign cpl_par   = lnk.cpl_in_sideband[CSB_PAR_LSB +: MAX_BYTES];

  // Checking stays on: there is no register through which to switch it off.
  logic parity_check_en;
  assign parity_check_en = 1'b1;

  assign cpl_par_err = parity_check_en &&
                       (((tsp_odd_parity(lnk.cpl_in_data) ^ cpl_par) & LANES) != '0);

  always_ff @(posedge lnk.clk or posedge lnk.sys_rst)
  begin
    if (lnk.sys_rst)
    begin
      bad_pkt_reg <= 1'b0;
    end
    else if (cpl_take)
    begin
      bad_pkt_reg <= !lnk.cpl_in_last && (bad_pkt_reg || cpl_abort || cpl_par_err);
    end
  end

  always_ff @(posedge lnk.clk or posedge lnk.sys_rst)
  begin
    if (lnk.sys_rst)
    begin
      tx_valid_reg   <= 1'b0;
      tx_data_reg    <= '0;
      tx_keep_reg    <= '0;
      tx_last_reg    <= 1'b0;
      tx_nullify_reg <= 1'b0;
    end
    else if (cpl_take)
    begin
      tx_valid_reg   <= 1'b1;
      tx_data_reg    <= lnk.cpl_in_data & DATA_LANES;
      tx_keep_reg    <= lnk.cpl_in_dword_keep & KEEP_LANES;
      tx_last_reg    <= lnk.cpl_in_last;
      tx_nullify_reg <= bad_pkt_reg || cpl_abort || cpl_par_err;
    end
    else if (tx_ready)
    begin
      tx_valid_reg <= 1'b0;
    end
  end

  assign tx_valid   = tx_valid_reg;
  assign tx_data    = tx_data_reg;
  assign tx_keep    = tx_keep_reg;
  assign tx_last    = tx_last_reg;
  assign tx_nullify = tx_nullify_reg;

  // Error reporting pulses.
  logic aer_reg;
  logic int_err_reg;

  always_ff @(posedge lnk.clk or posedge lnk.sys_rst)
  begin
    if (lnk.sys_rst)
    begin
      aer_reg     <= 1'b0;
      int_err_reg <= 1'b0;
    end
    else
    begin
      aer_reg <= endpoint_mode && ((rx_take && abort_now) ||
                 (cpl_take && cpl_abort && !bad_pkt_reg));
      int_err_reg <= cpl_take && cpl_par_err;
    end
  end

  assign aer_report   = aer_reg;
  assign internal_err = int_err_reg;
endmodule
`default_nettype wire

// file: logic/tsp_user_end.sv
`timescale 1ns/1ps
`default_nettype none
module tsp_user_end
#(
  parameter int DATA_W = 256
)
(
  tsp_link_if.user_end                   lnk,            // Link to the device end.
  input  wire logic                      usr_req_ready,  // User can take a request beat.
  output logic                           usr_req_valid,  // Request beat presented.
  output logic [tsp_pkg::MAX_DATA_W-1:0] usr_req_data,   // Request beat data.
  output logic [tsp_pkg::REQ_SB_W-1:0]   usr_req_sideband, // Request beat sideband.
  output logic                           usr_req_last,   // Last request beat.
  output logic                           usr_req_discard,// Drop the packet just ended.
  input  wire logic                      usr_cpl_valid,  // Completion beat offered.
  output logic                           usr_cpl_ready,  // Completion beat taken.
  input  wire logic [tsp_pkg::MAX_DATA_W-1:0] usr_cpl_data, // Completion beat data.
  input  wire logic [tsp_pkg::MAX_DWORDS-1:0] usr_cpl_keep, // Valid Dwords of beat.
  input  wire logic                      usr_cpl_last,   // Last completion beat.
  input  wire logic                      usr_cpl_abort,  // Abort this completion.
  input  wire logic                      parity_en       // Generate completion parity.
);
  import tsp_pkg::*;

  if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256)
  begin : g_bad_width
    $error("DATA_W must be 64, 128 or 256.");
  end

  localparam logic [MAX_BYTES-1:0] LANES = tsp_lane_mask(DATA_W);

  // Request side: pass beats through; abort marks the packet for discard.
  assign lnk.req_out_ready = usr_req_ready;
  assign usr_req_valid     = lnk.req_out_valid;
  assign usr_req_data      = lnk.req_out_data;
  assign usr_req_sideband  = lnk.req_out_sideband;
  assign usr_req_last      = lnk.req_out_last;
  assign usr_req_discard   = lnk.req_out_valid && lnk.req_out_last &&
                             lnk.req_out_sideband[SB_ABORT_BIT];

  // Completion side: one held stage, so the link sees stable beats under stall.
  logic                  cv_reg;
  logic [MAX_DATA_W-1:0] cd_reg;
  logic [CPL_SB_W-1:0]   cs_reg;
  logic                  cl_reg;
  logic [MAX_DWORDS-1:0] ck_reg;
  logic                  load;

  assign usr_cpl_ready = !cv_reg || lnk.cpl_in_ready;
  assign load          = usr_cpl_valid && usr_cpl_ready;

  always_ff @(posedge lnk.clk or posedge lnk.sys_rst)
  begin
    if (lnk.sys_rst)
    begin
      cv_reg <= 1'b0;
      cd_reg <= '0;
      cs_reg <= '0;
      cl_reg <= 1'b0;
      ck_reg <= '0;
    end
    else if (load)
    begin
      cv_reg <= 1'b1;
      cd_reg <= usr_cpl_data;
      cs_reg <= {(parity_en ? (tsp_odd_parity(usr_cpl_data) & LANES)
                            : {MAX_BYTES{1'b0}}),
                 usr_cpl_abort};
      cl_reg <= usr_cpl_last;
      ck_reg <= usr_cpl_keep;
    end
    else if (lnk.cpl_in_ready)
    begin
      cv_reg <= 1'b0;
      // Abort may only be shown with valid, so it leaves together with the beat.
      cs_reg[CSB_ABORT_BIT] <= 1'b0;
    end
  end

  assign lnk.cpl_in_valid      = cv_reg;
  assign lnk.cpl_in_data       = cd_reg;
  assign lnk.cpl_in_sideband   = cs_reg;
  assign lnk.cpl_in_last       = cl_reg;
  assign lnk.cpl_in_dword_keep = ck_reg;
endmodule
`default_nettype wire

// file: verification/tsp_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tsp_link_checker
#(
  parameter int DATA_W = 256
)
(
  input wire logic                            clk,               // Clock.
  input wire logic                            sys_rst,           // Reset.
  input wire logic [tsp_pkg::MAX_DATA_W-1:0]  req_out_data,      // Request data.
  input wire logic [tsp_pkg::REQ_SB_W-1:0]    req_out_sideband,  // Request sideband.
  input wire logic                            req_out_valid,     // Request valid.
  input wire logic                            req_out_ready,     // Request ready.
  input wire logic                            req_out_last,      // Request last.
  input wire logic [tsp_pkg::MAX_DATA_W-1:0]  cpl_in_data,       // Completion data.
  input wire logic [tsp_pkg::CPL_SB_W-1:0]    cpl_in_sideband,   // Completion sideband.
  input wire logic                            cpl_in_valid,      // Completion valid.
  input wire logic                            cpl_in_ready,      // Completion ready.
  input wire logic                            cpl_in_last,       // Completion last.
  input wire logic [tsp_pkg::MAX_DWORDS-1:0]  cpl_in_dword_keep  // Completion keep.
);
  import tsp_pkg::*;
  localparam logic [31:0] LANES = 32'hFFFFFFFF >> (32 - DATA_W / 8);
  logic        first_reg;
  logic [31:0] par_exp;
  wire logic   sop = req_out_sideband[SB_SOP_BIT];

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      first_reg <= 1'b1;
    else if (req_out_valid && req_out_ready)
      first_reg <= req_out_last;
  end

  always_comb
  begin
    for (int i = 0; i < 32; i++)
      par_exp[i] = LANES[i] & ~^req_out_data[8*i +: 8];
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence req_stall;
    req_out_valid && !req_out_ready;
  endsequence
  sequence cpl_stall;
    cpl_in_valid && !cpl_in_ready;
  endsequence

  chk_start_first: assert property (req_out_valid |-> sop == first_reg)
    else $error("start flag not on first beat");
  chk_mask_first: assert property (req_out_valid && !sop
    |-> req_out_sideband[7:0] == 8'h00) else $error("byte masks outside first beat");
  chk_hint_first: assert property (req_out_valid && !sop
    |-> req_out_sideband[52:42] == '0) else $error("hint fields outside first beat");
  chk_abort_last: assert property (req_out_valid && req_out_sideband[SB_ABORT_BIT]
    |-> req_out_last) else $error("abort outside last beat");
  chk_req_hold: assert property (req_stall |=> req_out_valid && $stable(req_out_data)
    && $stable(req_out_sideband) && $stable(req_out_last))
    else $error("stalled request beat changed");
  chk_req_parity: assert property (req_out_valid
    |-> req_out_sideband[84:53] == par_exp) else $error("request parity wrong");
  chk_byte_lanes: assert property (req_out_valid
    |-> (req_out_sideband[39:8] & ~LANES) == '0) else $error("byte valid set in unused lane");
  chk_cpl_hold: assert property (cpl_stall |=> cpl_in_valid && $stable(cpl_in_data)
    && $stable(cpl_in_sideband) && $stable(cpl_in_last) && $stable(cpl_in_dword_keep))
    else $error("stalled completion beat changed");
  chk_cpl_abort: assert property (cpl_in_sideband[CSB_ABORT_BIT] |-> cpl_in_valid)
    else $error("completion abort without valid");
  chk_cpl_paced: assert property (cpl_in_valid |-> ##[0:64] cpl_in_ready)
    else $error("completion never accepted");
endmodule
`default_nettype wire

// file: verification/tlp_stream_sideband_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tlp_stream_sideband_ports_tb;
  import tsp_pkg::*;
  // Narrow width, so that lane masking of data, byte valid, keep and parity is exercised.
  localparam int DW = 128;
  localparam logic [255:0] DMASK = (256'h1 << DW) - 256'h1;
  localparam logic [31:0]  BMASK = 32'hFFFFFFFF >> (32 - DW / 8);
  localparam logic [7:0]   KMASK = 8'hFF >> (8 - DW / 32);
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rx_valid = 1'b0, rx_last = 1'b0, rx_atomic_or_msg = 1'b0, rx_has_payload = 1'b0;
  logic rx_zero_len = 1'b0, rx_fifo_err = 1'b0, rx_hint_present = 1'b0, endpoint_mode = 1'b1;
  logic tx_ready = 1'b0, usr_req_ready = 1'b0, usr_cpl_valid = 1'b0, usr_cpl_last = 1'b0;
  logic usr_cpl_abort = 1'b0, parity_en = 1'b1, hold_req = 1'b0;
  logic [3:0] rx_lead_mask = 4'h0, rx_trail_mask = 4'h0;
  logic [1:0] rx_hint_kind = 2'h0;
  logic [7:0] rx_hint_steering_tag = 8'h00, usr_cpl_keep = 8'h00, tx_keep;
  logic [31:0] rx_payload_bytes = 32'h0;
  logic [255:0] rx_data = '0, usr_cpl_data = '0, tx_data, usr_req_data;
  logic rx_ready, aer_report, internal_err, tx_valid, tx_last, tx_nullify, usr_req_valid;
  logic usr_req_last, usr_req_discard, usr_cpl_ready;
  logic [87:0] usr_req_sideband;
  logic [344:0] req_q[$];
  logic [265:0] cpl_q[$];
  int errors = 0, check_count = 0, aer_exp = 0, aer_seen = 0, ierr_exp = 0, ierr_seen = 0;

  tsp_link_if tsp_link_if_inst (.clk(clk), .sys_rst(sys_rst));
  tsp_device_end #(.DATA_W(DW)) tsp_device_end_inst (
    .lnk(tsp_link_if_inst), .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_lead_mask,
    .rx_trail_mask, .rx_atomic_or_msg, .rx_has_payload, .rx_zero_len, .rx_payload_bytes,
    .rx_fifo_err, .rx_hint_present, .rx_hint_kind, .rx_hint_steering_tag, .endpoint_mode,
    .aer_report, .internal_err, .tx_valid, .tx_ready, .tx_data, .tx_keep, .tx_last,
    .tx_nullify);
  tsp_user_end #(.DATA_W(DW)) tsp_user_end_inst (
    .lnk(tsp_link_if_inst), .usr_req_ready, .usr_req_valid, .usr_req_data,
    .usr_req_sideband, .usr_req_last, .usr_req_discard, .usr_cpl_valid, .usr_cpl_ready,
    .usr_cpl_data, .usr_cpl_keep, .usr_cpl_last, .usr_cpl_abort, .parity_en);
  tsp_link_checker #(.DATA_W(DW)) tsp_link_checker_inst (
    .clk(clk), .sys_rst(sys_rst),
    .req_out_data(tsp_link_if_inst.req_out_data),
    .req_out_sideband(tsp_link_if_inst.req_out_sideband),
    .req_out_valid(tsp_link_if_inst.req_out_valid),
    .req_out_ready(tsp_link_if_inst.req_out_ready),
    .req_out_last(tsp_link_if_inst.req_out_last),
    .cpl_in_data(tsp_link_if_inst.cpl_in_data),
    .cpl_in_sideband(tsp_link_if_inst.cpl_in_sideband),
    .cpl_in_valid(tsp_link_if_inst.cpl_in_valid),
    .cpl_in_ready(tsp_link_if_inst.cpl_in_ready),
    .cpl_in_last(tsp_link_if_inst.cpl_in_last),
    .cpl_in_dword_keep(tsp_link_if_inst.cpl_in_dword_keep));

  initial
  begin
    forever #2 clk = ~clk;
  end

  task automatic fail(input string m);
    errors++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk_req(input logic [344:0] got, input logic disc);
    logic [344:0] e;
    e = req_q.size() ? req_q.pop_front() : 'x;
    check_count++;
    if (got !== e || disc !== (e[344] & e[297]))
      fail("request beat differs");
  endtask

  task automatic chk_cpl(input logic [265:0] got);
    logic [265:0] e;
    e = cpl_q.size() ? cpl_q.pop_front() : 'x;
    check_count++;
    if (got !== e)
      fail("completion beat differs");
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] e, input string m);
    check_count++;
    if (got !== e)
      fail(m);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic send_req(input int nb, input bit atom, input bit pay, input bit zl,
                          input bit err);
    logic [255:0] d;
    logic [87:0]  sb;
    logic [31:0]  r;
    logic [31:0]  pb;
    logic [10:0]  h;
    bit           bad;
    bad = 1'b0;
    @(posedge clk);
    for (int b = 0; b < nb; b++)
    begin
      for (int w = 0; w < 8; w++)
        d[32*w +: 32] = $urandom;
      r = $urandom;
      pb = $urandom;
      h = $urandom;
      if (!h[0])
        h = '0;
      bad |= err && b == 0;
      sb = '0;
      if (b == 0)
        sb[52:0] = {h, 2'h1, 32'h0, atom ? {MASK_ALL_ONES, MASK_ALL_ONES} : r[7:0]};
      sb[39:8] = (pay && !zl) ? pb & BMASK : 32'h0;
      sb[41] = pay && bad && b == nb - 1;
      for (int i = 0; i < DW / 8; i++)
        sb[53 + i] = ~^d[8*i +: 8];
      aer_exp += sb[41] && endpoint_mode;
      req_q.push_back({b == nb - 1, sb, d & DMASK});
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_last <= b == nb - 1;
      {rx_trail_mask, rx_lead_mask} <= r[7:0];
      {rx_hint_steering_tag, rx_hint_kind, rx_hint_present} <= h;
      rx_payload_bytes <= pb;
      rx_atomic_or_msg <= atom;
      rx_has_payload <= pay;
      rx_zero_len <= zl;
      rx_fifo_err <= err && b == 0;
      @(posedge clk);
      while (!rx_ready)
        @(posedge clk);
    end
    rx_valid <= 1'b0;
  endtask

  task automatic send_cpl(input int nb, input int ab);
    logic [255:0] d;
    logic [7:0]   k;
    bit           nul;
    bit           pe;
    nul = 1'b0;
    @(posedge clk);
    for (int b = 0; b < nb; b++)
    begin
      for (int w = 0; w < 8; w++)
        d[32*w +: 32] = $urandom;
      k = (b == nb - 1) ? 8'hFF >> ($urandom % 8) : 8'hFF;
      pe = 1'b0;
      for (int i = 0; i < DW / 8; i++)
        pe |= !parity_en && !(^d[8*i +: 8]);
      ierr_exp += pe;
      aer_exp += b == ab && endpoint_mode;
      nul |= pe || b == ab;
      cpl_q.push_back({nul, b == nb - 1, k & KMASK, d & DMASK});
      usr_cpl_valid <= 1'b1;
      usr_cpl_data <= d;
      usr_cpl_keep <= k;
      usr_cpl_last <= b == nb - 1;
      usr_cpl_abort <= b == ab;
      @(posedge clk);
      while (!usr_cpl_ready)
        @(posedge clk);
    end
    usr_cpl_valid <= 1'b0;
    usr_cpl_abort <= 1'b0;
  endtask

  always @(posedge clk)
  begin
    usr_req_ready <= !hold_req && $urandom % 4 != 0;
    tx_ready <= $urandom % 3 != 0;
    aer_seen += aer_report === 1'b1;
    ierr_seen += internal_err === 1'b1;
    if (usr_req_valid === 1'b1 && usr_req_ready)
      chk_req({usr_req_last, usr_req_sideband, usr_req_data},
              usr_req_discard);
    if (tx_valid === 1'b1 && tx_ready)
      chk_cpl({tx_nullify, tx_last, tx_keep, tx_data & DMASK});
  end

  initial
  begin
    void'($urandom(60));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // Request and completion aborts are kept apart, since two report pulses could merge.
    fork
      for (int n = 0; n < 24; n++)
        send_req(1 + n % 4, n % 5 == 0, n % 3 != 2, n % 7 == 3, n % 4 == 1);
      for (int n = 0; n < 24; n++)
        send_cpl(1 + n % 3, -1);
    join
    for (int n = 0; n < 8; n++)
    begin
      if (n == 6)
        endpoint_mode <= 1'b0;
      send_cpl(1 + n % 3, 0);
    end
    parity_en <= 1'b0;
    for (int n = 0; n < 4; n++)
      send_cpl(1, -1);
    hold_req <= 1'b1;
    fork
      send_req(3, 1'b0, 1'b1, 1'b0, 1'b0);
    join_none
    repeat (8) @(posedge clk);
    chk_val(rx_ready, 32'h0, "buffer did not refuse");
    hold_req <= 1'b0;
    wait fork;
    repeat (40) @(posedge clk);
    chk_val(aer_seen, aer_exp, "error report count");
    chk_val(ierr_seen, ierr_exp, "internal error count");
    chk_val(req_q.size() + cpl_q.size(), 32'h0, "beats not delivered");
    tally_and_finish();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fail("watchdog expired");
    tally_and_finish();
  end
endmodule
`default_nettype wire
